// ===== hdl/slic_cfg_defs.vh
// Purpose: constants for the line-interface, ring trip, level meter and FSK setup registers
// Assumes: one 20 MHz clock, command bytes arrive on the same clock
// Notes:   read form has command bit 7 low, write form has it high
//
// Summary of operation
// R1: pin-two data register, one bit per channel
// R2: command byte: bit 7 direction, seven bits code
// R3: pin-one direction bit: 0 input, 1 output
// R4: pin-two direction bit: 0 input, 1 output
// R5: ring output select picks one of five pins
// R6: ring trip enable bit gates trip function
// R7: off-hook taken from input one or two
// R8: off-hook polarity: 0 low, 1 high active
// R9: ring polarity: 0 drives low, 1 drives high
// R10: low result resets zero, bit0 ready flag
// R11: read low first; high read clears ready
// R12: sample count zero passes PCM straight through
// R13: count N meters N frames of 125 us
// R14: three-bit field picks metered channel
// R15: mode bit: compressed copy or linear metering
// R16: level meter on/off bit
// R17: teletax frequency 16 kHz or 12 kHz
// R18: tone invert bit flips dual-tone output
// R19: flag bit count 0 to 255
// R20: data byte count clamps to 64
// R21: zero byte count: mark or stop per setting
// R22: seizure count of '01' pairs, 0 to 510 bits
`ifndef SLIC_CFG_DEFS_VH
`define SLIC_CFG_DEFS_VH

// ==========================================================
// command byte
`define CMD_WRITE_BIT       7
`define CMD_CODE_W          7

// ==========================================================
// register codes
`define REG_PIN_TWO_DATA    7'h2B
`define REG_PIN_ONE_DIR     7'h2C
`define REG_PIN_TWO_DIR     7'h2D
`define REG_RING_TRIP       7'h2E
`define REG_METER_LOW       7'h30
`define REG_METER_HIGH      7'h31
`define REG_METER_COUNT     7'h32
`define REG_METER_TONE      7'h33
`define REG_FSK_FLAG        7'h34
`define REG_FSK_BYTES       7'h35
`define REG_FSK_SEIZURE     7'h36

// ==========================================================
// reset values
`define RST_BYTE            8'h00

// ==========================================================
// ring trip setting fields
`define RT_RING_SEL_LSB     0
`define RT_TRIP_EN_BIT      3
`define RT_HOOK_SEL_BIT     4
`define RT_HOOK_POL_BIT     5
`define RT_RING_POL_BIT     7
`define RING_TO_PIN_ONE     3'h3
`define RING_TO_PIN_TWO     3'h4
`define RING_TO_OUT_ONE     3'h5
`define RING_TO_OUT_TWO     3'h6
`define RING_TO_OUT_THREE   3'h7

// ==========================================================
// meter and tone control fields
`define MT_CH_LSB           0
`define MT_MODE_BIT         3
`define MT_ON_BIT           4
`define MT_TAX_FREQ_BIT     5
`define MT_TONE_INV_BIT     6

// ==========================================================
// FSK limits
`define FSK_MAX_BYTES       8'h40

// ==========================================================
// timing
// half periods of 16 kHz and 12 kHz at 20 MHz, rounded down
`define TAX_HALF_HI         10'h271
`define TAX_HALF_LO         10'h341

`endif

// ===== hdl/slic_ring_meter_fsk_config.v
// Purpose: global command registers for line pins, ring trip, level meter, teletax, tone and FSK setup
// Assumes: host bytes and PCM strobes are synchronous to clk_i; line inputs are asynchronous
// Notes:   PCM strobe marks one 125 us frame sample of the channel given with it
`timescale 1ns/1ps
`include "slic_cfg_defs.vh"

module slic_ring_meter_fsk_config (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        byte_valid_i,
  input  wire [7:0]  byte_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_valid_o,

  input  wire [7:0]  line_input_one_i,
  input  wire [7:0]  line_input_two_i,

  input  wire [7:0]  line_bidir_pin_one_i,
  input  wire [7:0]  line_bidir_pin_two_i,

  output reg  [7:0]  line_bidir_pin_one_o,
  output reg  [7:0]  line_bidir_pin_one_oe_o,
  output reg  [7:0]  line_bidir_pin_two_o,
  output reg  [7:0]  line_bidir_pin_two_oe_o,

  input  wire [7:0]  pin_one_data_i,
  input  wire [7:0]  out_one_data_i,
  input  wire [7:0]  out_two_data_i,
  input  wire [7:0]  out_three_data_i,

  output reg  [7:0]  line_output_one_o,
  output reg  [7:0]  line_output_two_o,
  output reg  [7:0]  line_output_three_o,

  input  wire [7:0]  ring_request_i,
  output reg  [7:0]  ring_tripped_o,

  input  wire        pcm_strobe_i,
  input  wire [2:0]  pcm_channel_i,
  input  wire [15:0] pcm_linear_i,
  input  wire [7:0]  pcm_comp_i,

  output reg         teletax_o,
  input  wire        tone_i,
  output reg         tone_o,

  input  wire        mark_after_send_i,
  output reg  [7:0]  flag_bit_count_o,
  output reg  [6:0]  data_byte_count_o,
  output reg  [8:0]  seizure_bit_count_o,
  output reg         send_words_o,
  output reg         send_mark_o
);

  // ==========================================================
  // constants
  localparam [9:0] TAX_HALF_HI = `TAX_HALF_HI;
  localparam [9:0] TAX_HALF_LO = `TAX_HALF_LO;

  localparam [1:0] ST_CMD   = 2'h0;
  localparam [1:0] ST_WDATA = 2'h1;

  // ==========================================================
  // registers
  reg [1:0]  state_reg;
  reg [6:0]  code_reg;

  reg [7:0]  pin_two_data_reg;
  reg [7:0]  pin_one_dir_reg;
  reg [7:0]  pin_two_dir_reg;
  reg [7:0]  ring_trip_reg;

  reg [7:0]  meter_low_reg;
  reg [7:0]  meter_high_reg;
  reg [7:0]  meter_count_reg;
  reg [7:0]  meter_tone_reg;
  reg [7:0]  fsk_flag_reg;
  reg [7:0]  fsk_bytes_reg;
  reg [7:0]  fsk_seizure_reg;

  reg [7:0]  in_one_meta_reg;
  reg [7:0]  in_one_reg;
  reg [7:0]  in_two_meta_reg;
  reg [7:0]  in_two_reg;

  reg [7:0]  trip_reg;

  reg [7:0]  frames_reg;
  reg [15:0] peak_reg;
  reg [9:0]  tax_cnt_reg;

  // ==========================================================
  // command decode
  wire       is_write  = byte_i[`CMD_WRITE_BIT];
  wire [6:0] code      = byte_i[6:0];

  wire       code_rw   = (code == `REG_PIN_TWO_DATA) || (code == `REG_PIN_ONE_DIR) ||
                         (code == `REG_PIN_TWO_DIR) || (code == `REG_RING_TRIP) ||
                         (code == `REG_METER_COUNT) || (code == `REG_METER_TONE) ||
                         (code == `REG_FSK_FLAG) || (code == `REG_FSK_BYTES) ||
                         (code == `REG_FSK_SEIZURE);
  wire       cmd_take  = byte_valid_i && (state_reg == ST_CMD);
  wire       rd_take   = cmd_take && !is_write;
  wire       wr_take   = byte_valid_i && (state_reg == ST_WDATA);
  wire       high_read = rd_take && (code == `REG_METER_HIGH);

  // ==========================================================
  // read multiplexer
  // reserved bits read back as zero
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (code == `REG_PIN_TWO_DATA) begin
      rd_mux = pin_two_data_reg;
    end else if (code == `REG_PIN_ONE_DIR) begin
      rd_mux = pin_one_dir_reg;
    end else if (code == `REG_PIN_TWO_DIR) begin
      rd_mux = pin_two_dir_reg;
    end else if (code == `REG_RING_TRIP) begin
      rd_mux = ring_trip_reg & 8'hBF;
    end else if (code == `REG_METER_LOW) begin
      rd_mux = meter_low_reg;
    end else if (code == `REG_METER_HIGH) begin
      rd_mux = meter_high_reg;
    end else if (code == `REG_METER_COUNT) begin
      rd_mux = meter_count_reg;
    end else if (code == `REG_METER_TONE) begin
      rd_mux = meter_tone_reg & 8'h7F;
    end else if (code == `REG_FSK_FLAG) begin
      rd_mux = fsk_flag_reg;
    end else if (code == `REG_FSK_BYTES) begin
      rd_mux = fsk_bytes_reg;
    end else if (code == `REG_FSK_SEIZURE) begin
      rd_mux = fsk_seizure_reg;
    end
  end

  // ==========================================================
  // host command state machine
  // read-only codes in write form are dropped with no data phase
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg  <= ST_CMD;
      code_reg   <= 7'h00;
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_take;
      if (rd_take) begin
        rd_data_o <= rd_mux;  // [R2]
      end
      case (state_reg)
        ST_CMD: begin
          if (cmd_take && is_write && code_rw) begin  // [R2]
            state_reg <= ST_WDATA;
            code_reg  <= code;
          end
        end
        // any valid byte ends the data phase, bit 7 included
        ST_WDATA: begin
          if (byte_valid_i) begin
            state_reg <= ST_CMD;
          end
        end
        default: begin
          state_reg <= ST_CMD;
        end
      endcase
    end
  end

  // ==========================================================
  // register file
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_two_data_reg <= `RST_BYTE;  // [R1]
      pin_one_dir_reg  <= `RST_BYTE;
      pin_two_dir_reg  <= `RST_BYTE;
      ring_trip_reg    <= `RST_BYTE;
      meter_count_reg  <= `RST_BYTE;
      meter_tone_reg   <= `RST_BYTE;
      fsk_flag_reg     <= `RST_BYTE;
      fsk_bytes_reg    <= `RST_BYTE;
      fsk_seizure_reg  <= `RST_BYTE;
    end else if (wr_take) begin
      if (code_reg == `REG_PIN_TWO_DATA) begin
        pin_two_data_reg <= byte_i;  // [R1]
      end else if (code_reg == `REG_PIN_ONE_DIR) begin
        pin_one_dir_reg <= byte_i;  // [R3]
      end else if (code_reg == `REG_PIN_TWO_DIR) begin
        pin_two_dir_reg <= byte_i;  // [R4]
      end else if (code_reg == `REG_RING_TRIP) begin
        ring_trip_reg <= byte_i;
      end else if (code_reg == `REG_METER_COUNT) begin
        meter_count_reg <= byte_i;
      end else if (code_reg == `REG_METER_TONE) begin
        meter_tone_reg <= byte_i;
      end else if (code_reg == `REG_FSK_FLAG) begin
        fsk_flag_reg <= byte_i;
      end else if (code_reg == `REG_FSK_BYTES) begin
        fsk_bytes_reg <= byte_i;
      end else if (code_reg == `REG_FSK_SEIZURE) begin
        fsk_seizure_reg <= byte_i;
      end
    end
  end

  // ==========================================================
  // ring trip
  // two flops per line input, the pins are asynchronous
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_one_meta_reg <= 8'h00;
      in_one_reg      <= 8'h00;
      in_two_meta_reg <= 8'h00;
      in_two_reg      <= 8'h00;
    end else begin
      in_one_meta_reg <= line_input_one_i;
      in_one_reg      <= in_one_meta_reg;
      in_two_meta_reg <= line_input_two_i;
      in_two_reg      <= in_two_meta_reg;
    end
  end

  // ==========================================================
  // ring routing
  wire [2:0] ring_sel  = ring_trip_reg[`RT_RING_SEL_LSB+2:`RT_RING_SEL_LSB];
  wire       trip_en   = ring_trip_reg[`RT_TRIP_EN_BIT];
  wire [7:0] hook_raw  = ring_trip_reg[`RT_HOOK_SEL_BIT] ? in_two_reg : in_one_reg;  // [R7]
  wire [7:0] offhook   = ring_trip_reg[`RT_HOOK_POL_BIT] ? hook_raw : ~hook_raw;  // [R8]
  wire       ring_on   = ring_trip_reg[`RT_RING_POL_BIT];
  wire [7:0] ringing   = ring_request_i & ~trip_reg;

  wire [7:0] ring_level;
  wire [7:0] trip_next;
  wire [7:0] pin_one_next;
  wire [7:0] pin_two_next;
  wire [7:0] out_one_next;
  wire [7:0] out_two_next;
  wire [7:0] out_three_next;
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_chan
      // a trip holds until ringing is withdrawn, so the line cannot re-ring by itself
      assign trip_next[ch]      = (trip_en && ring_request_i[ch] && offhook[ch]) ||
                                  (trip_reg[ch] && ring_request_i[ch]);  // [R6]
      assign ring_level[ch]     = ringing[ch] ? ring_on : ~ring_on;  // [R9]
      assign pin_one_next[ch]   = (ring_sel == `RING_TO_PIN_ONE) ? ring_level[ch] : pin_one_data_i[ch];  // [R5]
      assign pin_two_next[ch]   = (ring_sel == `RING_TO_PIN_TWO) ? ring_level[ch] : pin_two_data_reg[ch];  // [R5]
      assign out_one_next[ch]   = (ring_sel == `RING_TO_OUT_ONE) ? ring_level[ch] : out_one_data_i[ch];  // [R5]
      assign out_two_next[ch]   = (ring_sel == `RING_TO_OUT_TWO) ? ring_level[ch] : out_two_data_i[ch];  // [R5]
      assign out_three_next[ch] = (ring_sel == `RING_TO_OUT_THREE) ? ring_level[ch] : out_three_data_i[ch];  // [R5]
    end
  endgenerate

  // pad inputs are read back outside this block
  // ==========================================================
  // pin outputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trip_reg                <= 8'h00;
      ring_tripped_o          <= 8'h00;
      line_bidir_pin_one_o    <= 8'h00;
      line_bidir_pin_one_oe_o <= 8'h00;
      line_bidir_pin_two_o    <= 8'h00;
      line_bidir_pin_two_oe_o <= 8'h00;
      line_output_one_o       <= 8'h00;
      line_output_two_o       <= 8'h00;
      line_output_three_o     <= 8'h00;
    end else begin
      trip_reg                <= trip_next;  // [R6]
      ring_tripped_o          <= trip_next;
      line_bidir_pin_one_o    <= pin_one_next;
      line_bidir_pin_one_oe_o <= pin_one_dir_reg;  // [R3]
      line_bidir_pin_two_o    <= pin_two_next;  // [R1]
      line_bidir_pin_two_oe_o <= pin_two_dir_reg;  // [R4]
      line_output_one_o       <= out_one_next;
      line_output_two_o       <= out_two_next;
      line_output_three_o     <= out_three_next;
    end
  end

  // ==========================================================
  // level meter
  wire        meter_on   = meter_tone_reg[`MT_ON_BIT];
  wire        meter_lin  = meter_tone_reg[`MT_MODE_BIT];
  wire [2:0]  meter_ch   = meter_tone_reg[`MT_CH_LSB+2:`MT_CH_LSB];

  wire        sample_hit = meter_on && pcm_strobe_i && (pcm_channel_i == meter_ch);  // [R14] [R16]
  wire [15:0] magnitude  = pcm_linear_i[15] ? (16'h0000 - pcm_linear_i) : pcm_linear_i;

  wire [15:0] peak_next  = (magnitude > peak_reg) ? magnitude : peak_reg;
  wire        window_end = (frames_reg == meter_count_reg - 8'h01);

  // peak of the magnitude is kept instead of a mean, which would need a divider
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meter_low_reg  <= `RST_BYTE;  // [R10]
      meter_high_reg <= `RST_BYTE;
      frames_reg     <= 8'h00;
      peak_reg       <= 16'h0000;
    end else begin
      // a new result in the same cycle wins over the clear
      if (high_read) begin
        meter_low_reg[0] <= 1'b0;  // [R11]
      end
      if (!meter_on) begin
        frames_reg <= 8'h00;
        peak_reg   <= 16'h0000;
      end else if (sample_hit) begin
        if (!meter_lin) begin
          meter_high_reg <= pcm_comp_i;  // [R15]
          meter_low_reg  <= 8'h01;
        end else if (meter_count_reg == 8'h00) begin
          meter_high_reg <= pcm_linear_i[15:8];  // [R12]
          meter_low_reg  <= {pcm_linear_i[7:1], 1'b1};  // [R10]
        end else if (window_end) begin
          meter_high_reg <= peak_next[15:8];  // [R13]
          meter_low_reg  <= {peak_next[7:1], 1'b1};  // [R15]
          frames_reg     <= 8'h00;
          peak_reg       <= 16'h0000;
        end else begin
          frames_reg <= frames_reg + 8'h01;  // [R13]
          peak_reg   <= peak_next;
        end
      end
    end
  end

  // ==========================================================
  // teletax and tone
  wire [9:0] tax_half = meter_tone_reg[`MT_TAX_FREQ_BIT] ? TAX_HALF_LO : TAX_HALF_HI;  // [R17]

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tax_cnt_reg <= 10'h000;
      teletax_o   <= 1'b0;
      tone_o      <= 1'b0;
    end else begin
      tone_o <= tone_i ^ meter_tone_reg[`MT_TONE_INV_BIT];  // [R18]
      // a frequency change may cut the half in flight short
      if (tax_cnt_reg >= tax_half - 10'h001) begin
        tax_cnt_reg <= 10'h000;
        teletax_o   <= ~teletax_o;  // [R17]
      end else begin
        tax_cnt_reg <= tax_cnt_reg + 10'h001;
      end
    end
  end

  // ==========================================================
  // FSK lengths
  wire [7:0] bytes_eff = (fsk_bytes_reg > `FSK_MAX_BYTES) ? `FSK_MAX_BYTES : fsk_bytes_reg;  // [R20]
  wire       words_next = (bytes_eff != 8'h00);
  wire       mark_next  = !words_next && mark_after_send_i;  // [R21]

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_bit_count_o    <= 8'h00;
      data_byte_count_o   <= 7'h00;
      seizure_bit_count_o <= 9'h000;
      send_words_o        <= 1'b0;
      send_mark_o         <= 1'b0;
    end else begin
      flag_bit_count_o    <= fsk_flag_reg;  // [R19]
      data_byte_count_o   <= bytes_eff[6:0];  // [R20]
      seizure_bit_count_o <= {fsk_seizure_reg, 1'b0};  // [R22]
      send_words_o        <= words_next;  // [R21]
      send_mark_o         <= mark_next;  // [R21]
    end
  end

endmodule // slic_ring_meter_fsk_config

// ===== bench/slic_cfg_checker.sv
// Purpose: port assertions for the line, ring trip, meter and FSK setup block
// Assumes: one clock, asynchronous active-low reset
// Notes:   direction checks expect no data byte equal to a direction write command
`timescale 1ns/1ps
module slic_cfg_checker (
  input wire       clk_i,
  input wire       rstn_i,
  input wire       byte_valid_i,
  input wire [7:0] byte_i,
  input wire       rd_valid_o,
  input wire [7:0] line_bidir_pin_one_oe_o,
  input wire [7:0] line_bidir_pin_two_oe_o,
  input wire [7:0] ring_request_i,
  input wire [7:0] ring_tripped_o,
  input wire       teletax_o,
  input wire [6:0] data_byte_count_o,
  input wire [8:0] seizure_bit_count_o,
  input wire       send_words_o,
  input wire       send_mark_o
);
  // ====
  // teletax half period, counted since last toggle
  reg       last_reg;
  reg       seen_reg;
  reg [9:0] cnt_reg;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_reg <= 1'b0;
      seen_reg <= 1'b0;
      cnt_reg  <= 10'h000;
    end else begin
      last_reg <= teletax_o;
      if (teletax_o != last_reg) begin
        seen_reg <= 1'b1;
        cnt_reg  <= 10'h001;
      end else begin
        cnt_reg <= cnt_reg + 10'h001;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_RD_PULSE: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read answer longer than one cycle");
  AST_RD_CAUSE: assert property (rd_valid_o |-> $past(byte_valid_i) && !$past(byte_i[7]))
    else $error("read answer without read command");
  AST_DIR_ONE: assert property (($past(byte_valid_i, 3) && $past(byte_i, 3) == 8'hAC && $past(byte_valid_i, 2))
    |-> line_bidir_pin_one_oe_o == $past(byte_i, 2)) else $error("pin one direction not taken");
  AST_DIR_TWO: assert property (($past(byte_valid_i, 3) && $past(byte_i, 3) == 8'hAD && $past(byte_valid_i, 2))
    |-> line_bidir_pin_two_oe_o == $past(byte_i, 2)) else $error("pin two direction not taken");
  AST_TRIP_CAUSE: assert property ((ring_tripped_o & ~$past(ring_tripped_o) & ~$past(ring_request_i)) == 8'h00)
    else $error("trip without ring request");
  AST_TRIP_DROP: assert property ((ring_request_i == 8'h00) [*2] |-> ring_tripped_o == 8'h00)
    else $error("trip held after request dropped");
  AST_SEIZ_EVEN: assert property (seizure_bit_count_o[0] == 1'b0)
    else $error("seizure length odd");
  AST_BYTES_MAX: assert property (data_byte_count_o <= 7'h40)
    else $error("byte count above limit");
  AST_MARK_IDLE: assert property (send_mark_o |-> !send_words_o && data_byte_count_o == 7'h00)
    else $error("mark with word data");
  AST_TAX_HALF: assert property (seen_reg |-> cnt_reg <= 10'h341)
    else $error("teletax half period too long");
endmodule // slic_cfg_checker
bind slic_ring_meter_fsk_config slic_cfg_checker u_slic_cfg_checker (.clk_i, .rstn_i, .byte_valid_i, .byte_i,
  .rd_valid_o, .line_bidir_pin_one_oe_o, .line_bidir_pin_two_oe_o, .ring_request_i, .ring_tripped_o,
  .teletax_o, .data_byte_count_o, .seizure_bit_count_o, .send_words_o, .send_mark_o);

// ===== bench/slic_line_model.sv
// Purpose: line card model reporting hook state on one of its two status lines
// Assumes: hook state set by the bench
// Notes:   the unused line rests at its idle level
`timescale 1ns/1ps
module slic_line_model (
  input  wire [7:0] hook_i,
  input  wire       use_two_i,
  input  wire       active_high_i,
  output wire [7:0] line_input_one_o,
  output wire [7:0] line_input_two_o
);
  wire [7:0] on_one = hook_i & {8{~use_two_i}};
  wire [7:0] on_two = hook_i & {8{use_two_i}};
  assign line_input_one_o = active_high_i ? on_one : ~on_one;
  assign line_input_two_o = active_high_i ? on_two : ~on_two;
endmodule // slic_line_model

// ===== bench/slic_ring_meter_fsk_config_bench.sv
// Purpose: self-checking bench for the line, ring trip, meter and FSK setup block
// Assumes: inputs change on the falling edge
// Notes:   ring scenarios use channel 0 only
`timescale 1ns/1ps
module slic_ring_meter_fsk_config_bench;
  reg         clk_i = 1'b0, rstn_i = 1'b0, byte_valid_i = 1'b0, pcm_strobe_i = 1'b0;
  reg         tone_i = 1'b1, mark_after_send_i = 1'b0, use_two = 1'b0, act_high = 1'b0;
  reg  [7:0]  byte_i = 8'h00, line_bidir_pin_one_i = 8'h00, line_bidir_pin_two_i = 8'h00, hook = 8'h00;
  reg  [7:0]  pin_one_data_i = 8'h81, out_one_data_i = 8'h3D, out_two_data_i = 8'h5B, out_three_data_i = 8'h99;
  reg  [7:0]  ring_request_i = 8'h00, pcm_comp_i = 8'h00;
  reg  [2:0]  pcm_channel_i = 3'h0;
  reg  [15:0] pcm_linear_i = 16'h0000;
  wire [7:0]  rd_data_o, line_input_one_i, line_input_two_i, line_bidir_pin_one_o, line_bidir_pin_one_oe_o;
  wire [7:0]  line_bidir_pin_two_o, line_bidir_pin_two_oe_o, line_output_one_o, line_output_two_o;
  wire [7:0]  line_output_three_o, ring_tripped_o, flag_bit_count_o;
  wire [6:0]  data_byte_count_o;
  wire [8:0]  seizure_bit_count_o;
  wire        rd_valid_o, teletax_o, tone_o, send_words_o, send_mark_o;
  integer     err_total = 0, checks_done = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  slic_ring_meter_fsk_config u_slic_ring_meter_fsk_config (.*);
  slic_line_model u_slic_line_model (.hook_i(hook), .use_two_i(use_two), .active_high_i(act_high),
    .line_input_one_o(line_input_one_i), .line_input_two_o(line_input_two_i));
  // ====
  // shared tasks
  task chk(input string what, input [15:0] got, input [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0s exp=%h got=%h", what, exp, got);
    end
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, a few thousand cycles expected
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task wt(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  task wr(input [6:0] code, input [7:0] d);
    @(negedge clk_i); byte_valid_i = 1'b1; byte_i = {1'b1, code};
    @(negedge clk_i); byte_i = d;
    @(negedge clk_i); byte_valid_i = 1'b0;
  endtask
  task rdc(input [6:0] code, input [7:0] exp, input [7:0] mask);
    integer n;
    reg [7:0] v;
    @(negedge clk_i); byte_valid_i = 1'b1; byte_i = {1'b0, code};
    @(negedge clk_i); byte_valid_i = 1'b0; n = 0;
    while (rd_valid_o !== 1'b1 && n < 4) begin @(negedge clk_i); n = n + 1; end
    v = (n < 4) ? rd_data_o : {8{1'bx}}; // no answer must not match
    chk("read", v & mask, exp);
  endtask
  task wrc(input [6:0] code, input [7:0] d, input [7:0] exp);
    wr(code, d);
    rdc(code, exp, 8'hFF);
  endtask
  task strb(input [2:0] ch, input [15:0] lin, input [7:0] cp);
    @(negedge clk_i); pcm_strobe_i = 1'b1; pcm_channel_i = ch; pcm_linear_i = lin; pcm_comp_i = cp;
    @(negedge clk_i); pcm_strobe_i = 1'b0;
  endtask
  function [7:0] rpin(input [2:0] sel);
    case (sel)
      3'h3: rpin = line_bidir_pin_one_o;
      3'h4: rpin = line_bidir_pin_two_o;
      3'h5: rpin = line_output_one_o;
      3'h6: rpin = line_output_two_o;
      default: rpin = line_output_three_o;
    endcase
  endfunction
  // ====
  // scenarios
  task t_reset;
    integer c;
    for (c = 8'h2B; c <= 8'h36; c = c + 1) rdc(c[6:0], 8'h00, 8'hFF);
    chk("oe_one", line_bidir_pin_one_oe_o, 8'h00);
    chk("oe_two", line_bidir_pin_two_oe_o, 8'h00);
    chk("out_idle", {line_output_one_o, line_output_two_o}, 16'h3D5B);
  endtask
  task t_regs;
    wrc(7'h2B, 8'hFF, 8'hFF);
    wrc(7'h2C, 8'hFF, 8'hFF);
    wrc(7'h2D, 8'hFF, 8'hFF);
    wrc(7'h2E, 8'hFF, 8'hBF);
    wrc(7'h32, 8'hFF, 8'hFF);
    wrc(7'h33, 8'hFF, 8'h7F);
    wrc(7'h34, 8'hFF, 8'hFF);
    wrc(7'h35, 8'h3F, 8'h3F);
    wrc(7'h36, 8'hFF, 8'hFF);
    @(negedge clk_i); byte_valid_i = 1'b1; byte_i = 8'hB0; // write form of read-only code
    rdc(7'h30, 8'h00, 8'hFF);
  endtask
  task t_dir;
    wr(7'h2C, 8'hA5); wr(7'h2D, 8'h3D); wr(7'h2B, 8'h5A); wr(7'h2E, 8'h00); wt(2);
    chk("oe_one", line_bidir_pin_one_oe_o, 8'hA5);
    chk("oe_two", line_bidir_pin_two_oe_o, 8'h3D);
    chk("pin_one", line_bidir_pin_one_o & 8'hA5, 8'h81);
    chk("pin_two", line_bidir_pin_two_o & 8'h3D, 8'h18);
  endtask
  task t_ring(input [2:0] sel, input [7:0] cfg);
    act_high = cfg[5]; use_two = ~cfg[4]; hook = 8'h00;
    wr(7'h2E, cfg | {5'h00, sel});
    ring_request_i = 8'h01; wt(3);
    chk("ring_on", rpin(sel) & 8'h01, {7'h00, cfg[7]});
    hook = 8'h01; wt(6);
    chk("trip_other", ring_tripped_o, 8'h00);
    use_two = cfg[4]; wt(6);
    chk("trip", ring_tripped_o, {7'h00, cfg[3]});
    chk("ring_stop", rpin(sel) & 8'h01, {7'h00, cfg[7] ^ cfg[3]});
    ring_request_i = 8'h00; hook = 8'h00; wt(4);
    chk("trip_clear", ring_tripped_o, 8'h00);
  endtask
  task t_meter;
    wr(7'h33, 8'h12); strb(3'h2, 16'h0000, 8'hC3);
    rdc(7'h30, 8'h01, 8'hFF);
    rdc(7'h31, 8'hC3, 8'hFF);
    rdc(7'h30, 8'h00, 8'h01);
    strb(3'h5, 16'h0000, 8'h11);
    rdc(7'h30, 8'h00, 8'h01);
    wr(7'h33, 8'h1A); wr(7'h32, 8'h00); strb(3'h2, 16'h1234, 8'h00);
    rdc(7'h30, 8'h35, 8'hFF);
    rdc(7'h31, 8'h12, 8'hFF);
    wr(7'h32, 8'h03); strb(3'h2, 16'h0100, 8'h00); strb(3'h2, 16'hFE00, 8'h00);
    rdc(7'h30, 8'h00, 8'h01);
    strb(3'h2, 16'h0080, 8'h00);
    rdc(7'h30, 8'h01, 8'hFF);
    rdc(7'h31, 8'h02, 8'hFF);
    wr(7'h33, 8'h0A); wr(7'h32, 8'h00); strb(3'h2, 16'h7777, 8'h00);
    rdc(7'h30, 8'h00, 8'h01);
  endtask
  task t_tax(input [7:0] cfg, input [15:0] half);
    integer n;
    reg t;
    wr(7'h33, cfg);
    n = 0; t = teletax_o;
    while (teletax_o === t && n < 2000) begin wt(1); n = n + 1; end // skip half in flight
    n = 0; t = teletax_o;
    while (teletax_o === t && n < 2000) begin wt(1); n = n + 1; end
    chk("tax_half", n[15:0], half);
    chk("tone", tone_o, {15'h0000, ~cfg[6]});
    tone_i = 1'b0; wt(2);
    chk("tone_low", tone_o, {15'h0000, cfg[6]});
    tone_i = 1'b1;
  endtask
  task t_fsk;
    integer i;
    wr(7'h34, 8'hFF); wt(2);
    chk("flags", flag_bit_count_o, 8'hFF);
    for (i = 0; i < 4; i = i + 1) begin
      wr(7'h35, {i[1:0], 6'h3F}); wt(2);
      chk("bytes", data_byte_count_o, (i == 0) ? 16'h003F : 16'h0040);
    end
    wr(7'h36, 8'hFF); wt(2);
    chk("seizure", seizure_bit_count_o, 16'h01FE);
    wr(7'h35, 8'h00); mark_after_send_i = 1'b1; wt(2);
    chk("mark", {send_words_o, send_mark_o}, 16'h0001);
    mark_after_send_i = 1'b0; wt(2);
    chk("mute", {send_words_o, send_mark_o}, 16'h0000);
    wr(7'h34, 8'h00); wr(7'h36, 8'h00); wt(2);
    chk("flags_off", flag_bit_count_o, 8'h00);
    chk("seizure_off", seizure_bit_count_o, 16'h0000);
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    t_reset; t_regs; t_dir;
    t_ring(3'h5, 8'h08); t_ring(3'h6, 8'h18); t_ring(3'h7, 8'h28);
    t_ring(3'h3, 8'h88); t_ring(3'h4, 8'h08); t_ring(3'h5, 8'h00);
    wr(7'h2E, 8'h0A); ring_request_i = 8'h01; wt(3);
    chk("undef_sel", {line_output_one_o, line_output_two_o}, 16'h3D5B);
    ring_request_i = 8'h00;
    t_meter; t_tax(8'h00, 16'd625); t_tax(8'h60, 16'd833); t_fsk;
    end_sim;
  end
endmodule // slic_ring_meter_fsk_config_bench
